// >>> logic/rfs_regs.vh
// Purpose: register offsets, field positions and reset values of the reference input selector
// Assumes: register index equals the byte address on the plain register port
// Notes:   definitions only
`ifndef RFS_REGS_VH
`define RFS_REGS_VH

`define RFS_ADDR_W          6
`define RFS_DATA_W          16

`define RFS_OFS_ZDM         6'h00
`define RFS_OFS_MUX         6'h02
`define RFS_OFS_BUF         6'h18
`define RFS_OFS_RDIV        6'h19
`define RFS_OFS_BYPASS      6'h3E
`define RFS_OFS_STATUS      6'h3F

`define RFS_ZERO_DELAY_ENABLE_BIT      8
`define RFS_ZDM_FBSEL_BIT   10
`define RFS_MUX_LSB         0
`define RFS_MUX_MSB         1
`define RFS_SECBUF_LSB      0
`define RFS_SECBUF_MSB      1
`define RFS_DRIVE_LSB       2
`define RFS_DRIVE_MSB       5
`define RFS_LOAD_LSB        8
`define RFS_LOAD_MSB        12
`define RFS_PRIBUF_BIT      15
`define RFS_RDIV_LSB        0
`define RFS_RDIV_MSB        7
`define RFS_BYP_EN_BIT      0
`define RFS_BYP_SRC_BIT     1

`define RFS_MASK_ZDM        16'h0500
`define RFS_MASK_MUX        16'h0003
`define RFS_MASK_BUF        16'h9F3F
`define RFS_MASK_RDIV       16'h00FF
`define RFS_MASK_BYPASS     16'h0003

`define RFS_RST_ZDM         16'h0000
`define RFS_RST_MUX         16'h0000
`define RFS_RST_BUF         16'h0000
`define RFS_RST_RDIV        16'h0001
`define RFS_RST_BYPASS      16'h0000

`define RFS_MUX_FORCE_SEC   2'h2
`define RFS_MUX_FORCE_PRI   2'h3
`define RFS_SECBUF_XO       2'h0
`define RFS_SECBUF_CMOS     2'h1

`endif

// >>> logic/rfs_ref_divider.v
// Purpose: reference divider and doubler acting on a sampled reference level
// Assumes: ref_level is already synchronised to clock
// Notes:   pfd_tick marks one phase-detector period; pfd_level toggles per tick
`timescale 1ns/1ps
module rfs_ref_divider #(
  parameter DIV_W = 8
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             ref_level,
  input  wire [DIV_W-1:0] div_value,
  output reg              pfd_tick,
  output reg              pfd_level
);
  reg             prev_reg;
  reg [DIV_W-1:0] count_reg;
  wire            rise;
  wire            fall;
  wire            doubler;

  assign rise    = ref_level & ~prev_reg;
  assign fall    = ~ref_level & prev_reg;
  assign doubler = (div_value == {DIV_W{1'b0}});

  always @(posedge clock) begin
    if (!rst_n) begin
      prev_reg  <= 1'b0;
      count_reg <= {DIV_W{1'b0}};
      pfd_tick  <= 1'b0;
      pfd_level <= 1'b0;
    end else begin
      prev_reg <= ref_level;
      pfd_tick <= 1'b0;
      if (doubler) begin
        // zero setting: every input edge is a phase-detector event, twice the input rate
        count_reg <= {DIV_W{1'b0}};
        if (rise | fall) begin
          pfd_tick  <= 1'b1;
          pfd_level <= ~pfd_level;
        end
      end else if (rise) begin
        if (count_reg >= div_value - {{(DIV_W-1){1'b0}}, 1'b1}) begin
          count_reg <= {DIV_W{1'b0}};
          pfd_tick  <= 1'b1;
          pfd_level <= ~pfd_level;
        end else begin
          count_reg <= count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// >>> logic/rfs_ref_select.v
// Purpose: reference input front end: input mux, buffer modes, divider, bypass, zero delay
// Assumes: register port on clock; pins and reference levels are asynchronous
// Notes:   every output is registered; route_primary follows a write one edge after the other outputs
`timescale 1ns/1ps
`include "rfs_regs.vh"

// What this block does
// - with pin control, low pin routes secondary input, high routes primary.
// - override 0 or 1 follows pin; 2 forces secondary; 3 forces primary.
// - secondary buffer 0 crystal, 1 single-ended CMOS, 2 or 3 differential.
// - primary buffer 0 single-ended CMOS, 1 differential.
// - differential mode engages pin bias; crystal or CMOS disengages it.
// - reference divider divides; zero engages the doubler at twice input rate.
// - five-bit field sets crystal load capacitor array, up to nine picofarads.
// - four-bit field sets crystal oscillator drive strength.
// - bypass to outputs selects raw input clock or phase-detector clock.
// - zero-delay enable makes primary input the phase-detector reference.
// - in zero delay, feedback select 1 uses secondary input, 0 channel two.
// - zero delay, once enabled, acquires lock by itself when dividers are lockable.
module rfs_ref_select #(
  parameter DIV_W = 8
) (
  input  wire                   clock,
  input  wire                   rst_n,
  input  wire [`RFS_ADDR_W-1:0] reg_addr,
  input  wire [`RFS_DATA_W-1:0] reg_wdata,
  input  wire                   reg_write,
  input  wire                   reg_read,
  output reg  [`RFS_DATA_W-1:0] reg_rdata,
  input  wire                   ref_select_pin,
  input  wire                   primary_input,
  input  wire                   secondary_input,
  input  wire                   dividers_lockable,
  output reg                    crystal_oscillator_enable,
  output reg                    secondary_cmos_enable,
  output reg                    secondary_diff_enable,
  output reg                    secondary_bias_enable,
  output reg                    primary_cmos_enable,
  output reg                    primary_diff_enable,
  output reg                    primary_bias_enable,
  output reg  [4:0]             crystal_load_cap,
  output reg  [3:0]             crystal_drive,
  output reg                    route_primary,
  output reg                    feedback_from_secondary,
  output reg                    feedback_from_channel2,
  output reg                    doubler_enable,
  output reg                    pll_acquire,
  output reg                    pfd_tick,
  output reg                    pfd_clock,
  output reg                    bypass_enable,
  output reg                    bypass_clock
);
  reg  [`RFS_DATA_W-1:0] zdm_reg;
  reg  [`RFS_DATA_W-1:0] mux_reg;
  reg  [`RFS_DATA_W-1:0] buf_reg;
  reg  [`RFS_DATA_W-1:0] rdiv_reg;
  reg  [`RFS_DATA_W-1:0] bypass_reg;
  reg  [`RFS_DATA_W-1:0] rdata_next;

  // two-stage synchronisers: stage one feeds only stage two
  reg  [2:0]             sync1_reg;
  reg  [2:0]             sync2_reg;
  wire                   pin_level;
  wire                   pri_level;
  wire                   sec_level;

  wire [1:0]             mux_override;
  wire [1:0]             secondary_buffer_type;
  wire                   primary_buffer_type;
  wire                   zero_delay_enable;
  wire                   zero_delay_feedback_select;
  wire [DIV_W-1:0]       reference_divider;
  reg                    choose_primary;
  reg                    choose_primary_reg;
  wire                   sel_level;
  reg                    sel_level_reg;
  wire                   div_tick;
  wire                   div_level;

  function [`RFS_DATA_W-1:0] masked;
    input [`RFS_DATA_W-1:0] value;
    input [`RFS_DATA_W-1:0] mask;
    begin
      masked = value & mask;
    end
  endfunction

  function is_diff_sec;
    input [1:0] mode;
    begin
      is_diff_sec = mode[1];
    end
  endfunction

  // register writes: whole fields land in one edge
  always @(posedge clock) begin
    if (!rst_n) begin
      zdm_reg    <= `RFS_RST_ZDM;
      mux_reg    <= `RFS_RST_MUX;
      buf_reg    <= `RFS_RST_BUF;
      rdiv_reg   <= `RFS_RST_RDIV;
      bypass_reg <= `RFS_RST_BYPASS;
    end else if (reg_write) begin
      case (reg_addr)
        `RFS_OFS_ZDM: begin
          zdm_reg <= masked(reg_wdata, `RFS_MASK_ZDM);
        end
        `RFS_OFS_MUX: begin
          mux_reg <= masked(reg_wdata, `RFS_MASK_MUX);
        end
        `RFS_OFS_BUF: begin
          buf_reg <= masked(reg_wdata, `RFS_MASK_BUF);
        end
        `RFS_OFS_RDIV: begin
          rdiv_reg <= masked(reg_wdata, `RFS_MASK_RDIV);
        end
        `RFS_OFS_BYPASS: begin
          bypass_reg <= masked(reg_wdata, `RFS_MASK_BYPASS);
        end
        default: begin
          zdm_reg <= zdm_reg;
        end
      endcase
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {secondary_input, primary_input, ref_select_pin};
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_level = sync2_reg[0];
  assign pri_level = sync2_reg[1];
  assign sec_level = sync2_reg[2];

  assign mux_override               = mux_reg[`RFS_MUX_MSB:`RFS_MUX_LSB];
  assign secondary_buffer_type      = buf_reg[`RFS_SECBUF_MSB:`RFS_SECBUF_LSB];
  assign primary_buffer_type        = buf_reg[`RFS_PRIBUF_BIT];
  assign zero_delay_enable          = zdm_reg[`RFS_ZERO_DELAY_ENABLE_BIT];
  assign zero_delay_feedback_select = zdm_reg[`RFS_ZDM_FBSEL_BIT];
  assign reference_divider          = rdiv_reg[DIV_W-1:0];

  // reference choice for the phase detector
  always @* begin
    if (zero_delay_enable) begin
      choose_primary = 1'b1;
    end else begin
      case (mux_override)
        `RFS_MUX_FORCE_SEC: choose_primary = 1'b0;
        `RFS_MUX_FORCE_PRI: choose_primary = 1'b1;
        default:            choose_primary = pin_level;
      endcase
    end
  end

  assign sel_level = choose_primary_reg ? pri_level : sec_level;

  always @(posedge clock) begin
    if (!rst_n) begin
      choose_primary_reg <= 1'b0;
      sel_level_reg      <= 1'b0;
    end else begin
      choose_primary_reg <= choose_primary;
      sel_level_reg      <= sel_level;
    end
  end

  rfs_ref_divider #(
    .DIV_W (DIV_W)
  ) u_divider (
    .clock     (clock),
    .rst_n     (rst_n),
    .ref_level (sel_level),
    .div_value (reference_divider),
    .pfd_tick  (div_tick),
    .pfd_level (div_level)
  );

  // buffer, crystal and routing outputs, all registered from the committed fields
  always @(posedge clock) begin
    if (!rst_n) begin
      crystal_oscillator_enable <= 1'b1;
      secondary_cmos_enable     <= 1'b0;
      secondary_diff_enable     <= 1'b0;
      secondary_bias_enable     <= 1'b0;
      primary_cmos_enable       <= 1'b1;
      primary_diff_enable       <= 1'b0;
      primary_bias_enable       <= 1'b0;
      crystal_load_cap          <= 5'h00;
      crystal_drive             <= 4'h0;
      route_primary             <= 1'b0;
      feedback_from_secondary   <= 1'b0;
      feedback_from_channel2    <= 1'b0;
      doubler_enable            <= 1'b0;
      pll_acquire               <= 1'b0;
      pfd_tick                  <= 1'b0;
      pfd_clock                 <= 1'b0;
      bypass_enable             <= 1'b0;
      bypass_clock              <= 1'b0;
    end else begin
      crystal_oscillator_enable <= (secondary_buffer_type == `RFS_SECBUF_XO);
      secondary_cmos_enable     <= (secondary_buffer_type == `RFS_SECBUF_CMOS);
      secondary_diff_enable     <= is_diff_sec(secondary_buffer_type);
      secondary_bias_enable     <= is_diff_sec(secondary_buffer_type);
      primary_cmos_enable       <= ~primary_buffer_type;
      primary_diff_enable       <= primary_buffer_type;
      primary_bias_enable       <= primary_buffer_type;
      crystal_load_cap          <= buf_reg[`RFS_LOAD_MSB:`RFS_LOAD_LSB];
      crystal_drive             <= buf_reg[`RFS_DRIVE_MSB:`RFS_DRIVE_LSB];
      route_primary             <= choose_primary_reg;
      // external feedback rides on the secondary pins
      feedback_from_secondary   <= zero_delay_enable & zero_delay_feedback_select;
      // internal path needs channel two kept powered by software
      feedback_from_channel2    <= zero_delay_enable & ~zero_delay_feedback_select;
      doubler_enable            <= (reference_divider == {DIV_W{1'b0}});
      // no software kick: lock is acquired once the dividers are lockable
      pll_acquire               <= zero_delay_enable & dividers_lockable;
      pfd_tick                  <= div_tick;
      pfd_clock                 <= div_level;
      bypass_enable             <= bypass_reg[`RFS_BYP_EN_BIT];
      if (bypass_reg[`RFS_BYP_EN_BIT]) begin
        bypass_clock <= bypass_reg[`RFS_BYP_SRC_BIT] ? div_level : sel_level_reg;
      end else begin
        bypass_clock <= 1'b0;
      end
    end
  end

  // read path: data in the cycle after the strobe only, unmapped reads zero
  always @* begin
    case (reg_addr)
      `RFS_OFS_ZDM:    rdata_next = zdm_reg;
      `RFS_OFS_MUX:    rdata_next = mux_reg;
      `RFS_OFS_BUF:    rdata_next = buf_reg;
      `RFS_OFS_RDIV:   rdata_next = rdiv_reg;
      `RFS_OFS_BYPASS: rdata_next = bypass_reg;
      `RFS_OFS_STATUS: rdata_next = {9'h000, sel_level_reg, div_level, pll_acquire,
                                     doubler_enable, feedback_from_secondary,
                                     choose_primary_reg, pin_level};
      default:         rdata_next = 16'h0000;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

// >>> verif/rfs_ref_source.sv
// Purpose: free-running reference clocks standing in for the far-side sources
// Assumes: both sources run continuously, slower than half the system clock
// Notes:   periods are 5 and 7 system clocks so the two inputs are told apart
`timescale 1ns/1ps
module rfs_ref_source #(
  parameter real PRI_HALF = 100.0,
  parameter real SEC_HALF = 140.0
) (
  output logic primary_input,
  output logic secondary_input
);
  initial begin
    primary_input = 1'b0;
    secondary_input = 1'b0;
  end
  always #(PRI_HALF) primary_input = ~primary_input;
  always #(SEC_HALF) secondary_input = ~secondary_input;
endmodule

// >>> verif/rfs_ref_select_chk.sv
// Purpose: port checks of the reference input selector
// Assumes: outputs settle within seven quiet cycles after a write or pin change
// Notes:   register shadows are rebuilt from the write port
`timescale 1ns/1ps
`include "rfs_regs.vh"
module rfs_ref_select_chk #(
  parameter DIV_W = 8
) (
  input wire                   clock,
  input wire                   rst_n,
  input wire [`RFS_ADDR_W-1:0] reg_addr,
  input wire [`RFS_DATA_W-1:0] reg_wdata,
  input wire                   reg_write,
  input wire                   ref_select_pin,
  input wire                   dividers_lockable,
  input wire                   crystal_oscillator_enable,
  input wire                   secondary_cmos_enable,
  input wire                   secondary_diff_enable,
  input wire                   secondary_bias_enable,
  input wire                   primary_cmos_enable,
  input wire                   primary_diff_enable,
  input wire                   primary_bias_enable,
  input wire [4:0]             crystal_load_cap,
  input wire [3:0]             crystal_drive,
  input wire                   route_primary,
  input wire                   feedback_from_secondary,
  input wire                   feedback_from_channel2,
  input wire                   doubler_enable,
  input wire                   pll_acquire,
  input wire                   bypass_enable,
  input wire                   bypass_clock
);
  logic [2:0]  quiet;
  logic        pin_q;
  logic        lock_q;
  logic [15:0] zdm_s;
  logic [15:0] mux_s;
  logic [15:0] buf_s;
  logic [15:0] rdiv_s;
  logic [15:0] byp_s;
  wire         exp_route = zdm_s[8] | (mux_s[1] ? mux_s[0] : pin_q);
  wire         wr_buf = reg_write && reg_addr == `RFS_OFS_BUF;
  always @(posedge clock) begin
    pin_q <= ref_select_pin;
    lock_q <= dividers_lockable;
    if (!rst_n) begin
      quiet <= 3'h0;
      zdm_s <= `RFS_RST_ZDM;
      mux_s <= `RFS_RST_MUX;
      buf_s <= `RFS_RST_BUF;
      rdiv_s <= `RFS_RST_RDIV;
      byp_s <= `RFS_RST_BYPASS;
    end else begin
      if (reg_write || pin_q != ref_select_pin || lock_q != dividers_lockable)
        quiet <= 3'h0;
      else if (quiet != 3'h7)
        quiet <= quiet + 3'h1;
      if (reg_write && reg_addr == `RFS_OFS_ZDM) zdm_s <= reg_wdata & `RFS_MASK_ZDM;
      if (reg_write && reg_addr == `RFS_OFS_MUX) mux_s <= reg_wdata & `RFS_MASK_MUX;
      if (wr_buf) buf_s <= reg_wdata & `RFS_MASK_BUF;
      if (reg_write && reg_addr == `RFS_OFS_RDIV) rdiv_s <= reg_wdata & `RFS_MASK_RDIV;
      if (reg_write && reg_addr == `RFS_OFS_BYPASS) byp_s <= reg_wdata & `RFS_MASK_BYPASS;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_route_select: assert property (quiet == 3'h7 |-> route_primary == exp_route)
    else $error("selected reference differs from pin and override");
  a_sec_buffer: assert property (quiet == 3'h7 |-> {crystal_oscillator_enable,
    secondary_cmos_enable, secondary_diff_enable} == {buf_s[1:0] == 2'h0, buf_s[1:0] == 2'h1, buf_s[1]})
    else $error("secondary buffer mode wrong");
  a_bias_follow: assert property (quiet == 3'h7 |-> secondary_bias_enable == buf_s[1]
    && primary_bias_enable == buf_s[15]) else $error("bias does not follow differential mode");
  a_pri_write: assert property (wr_buf && reg_wdata[15] |-> ##[1:4]
    primary_diff_enable && !primary_cmos_enable) else $error("primary differential not applied");
  a_trim_fields: assert property (quiet == 3'h7 |-> crystal_load_cap == buf_s[12:8]
    && crystal_drive == buf_s[5:2]) else $error("crystal load or drive wrong");
  a_doubler_write: assert property (reg_write && reg_addr == `RFS_OFS_RDIV
    && reg_wdata[7:0] == 8'h00 |-> ##[1:4] doubler_enable) else $error("doubler not engaged");
  a_doubler_level: assert property (quiet == 3'h7 |-> doubler_enable == (rdiv_s[7:0] == 8'h00))
    else $error("doubler level wrong");
  a_zero_feedback: assert property (quiet == 3'h7 |-> {feedback_from_secondary,
    feedback_from_channel2} == {zdm_s[8] & zdm_s[10], zdm_s[8] & !zdm_s[10]}) else $error("feedback path wrong");
  a_lock_acquire: assert property (quiet == 3'h7 |-> pll_acquire == (zdm_s[8] && lock_q))
    else $error("acquire level wrong");
  a_bypass_idle: assert property (quiet == 3'h7 && !byp_s[0] |-> !bypass_enable && !bypass_clock)
    else $error("bypass active while disabled");
  cover property (quiet == 3'h7 && route_primary && !zdm_s[8]);
  cover property (feedback_from_secondary && pll_acquire);
  cover property (doubler_enable && quiet == 3'h7);
  cover property (bypass_enable && bypass_clock);
endmodule

bind rfs_ref_select rfs_ref_select_chk #(.DIV_W(DIV_W)) rfs_ref_select_chk_i (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .ref_select_pin(ref_select_pin), .dividers_lockable(dividers_lockable),
  .crystal_oscillator_enable(crystal_oscillator_enable), .secondary_cmos_enable(secondary_cmos_enable),
  .secondary_diff_enable(secondary_diff_enable), .secondary_bias_enable(secondary_bias_enable),
  .primary_cmos_enable(primary_cmos_enable), .primary_diff_enable(primary_diff_enable),
  .primary_bias_enable(primary_bias_enable), .crystal_load_cap(crystal_load_cap),
  .crystal_drive(crystal_drive), .route_primary(route_primary),
  .feedback_from_secondary(feedback_from_secondary), .feedback_from_channel2(feedback_from_channel2),
  .doubler_enable(doubler_enable), .pll_acquire(pll_acquire), .bypass_enable(bypass_enable),
  .bypass_clock(bypass_clock));

// >>> verif/rfs_ref_select_tb.sv
// Purpose: register-driven scenarios for the reference input selector
// Assumes: outputs settle within eight cycles of a write
// Notes:   tick counts allow one edge of slack for synchroniser phase
`timescale 1ns/1ps
`include "rfs_regs.vh"
module rfs_ref_select_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        ref_select_pin = 1'b0;
  logic        dividers_lockable = 1'b0;
  logic [15:0] v;
  logic [15:0] e;
  wire  [15:0] reg_rdata;
  wire  [4:0]  load;
  wire  [3:0]  drive;
  wire         pri, sec, xo, scm, sdf, sbi, pcm, pdf, pbi, rpri, fbs, fb2, dbl, acq, tick, byc;
  wire         pfc;
  wire         bye;
  int          failures = 0;
  int          checks_done = 0;
  int          n;
  logic [5:0]  adr [6] = '{6'h00, 6'h02, 6'h18, 6'h19, 6'h3E, 6'h10};
  logic [15:0] rsv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
  logic [15:0] msk [6] = '{16'h0500, 16'h0003, 16'h9F3F, 16'h00FF, 16'h0003, 16'h0000};
  always #20 clock = ~clock;
  rfs_ref_source rfs_ref_source_i (.primary_input(pri), .secondary_input(sec));
  rfs_ref_select #(.DIV_W(8)) rfs_ref_select_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ref_select_pin(ref_select_pin), .primary_input(pri), .secondary_input(sec),
    .dividers_lockable(dividers_lockable), .crystal_oscillator_enable(xo),
    .secondary_cmos_enable(scm), .secondary_diff_enable(sdf), .secondary_bias_enable(sbi),
    .primary_cmos_enable(pcm), .primary_diff_enable(pdf), .primary_bias_enable(pbi),
    .crystal_load_cap(load), .crystal_drive(drive), .route_primary(rpri),
    .feedback_from_secondary(fbs), .feedback_from_channel2(fb2), .doubler_enable(dbl),
    .pll_acquire(acq), .pfd_tick(tick), .pfd_clock(pfc), .bypass_enable(bye),
    .bypass_clock(byc));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] x);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, x);
  endtask
  // counts tick pulses (0), or rising edges of the bypass clock (1) or phase-detector clock (2)
  task automatic tcount(input logic [1:0] src, input int x);
    logic p;
    logic s;
    n = 0;
    p = 1'b0;
    repeat (300) begin
      @(posedge clock);
      #1;
      s = (src == 2'h0) ? tick : ((src == 2'h1) ? byc : pfc);
      if (s === 1'b1 && (src == 2'h0 || p !== 1'b1)) n++;
      p = s;
    end
    chk((n >= x - 1 && n <= x + 1) ? x[15:0] : n[15:0], x[15:0]);
  endtask
  task automatic results;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    results;
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(adr[i], rsv[i]);
    for (int i = 0; i < 6; i++) begin
      wr(adr[i], 16'hFFFF);
      rd(adr[i], msk[i]);
      wr(adr[i], rsv[i]);
    end
    for (int m = 0; m < 8; m++) begin
      wr(`RFS_OFS_MUX, 16'(m / 2));
      ref_select_pin <= m[0];
      repeat (8) @(posedge clock);
      chk(16'(rpri), (m > 3) ? 16'(m / 2 - 2) : 16'(m[0]));
    end
    for (int s = 0; s < 8; s++) begin
      v = {s[2], 2'b00, 5'(31 - s * 4), 2'b00, 4'(15 - s * 2), s[1:0]};
      wr(`RFS_OFS_BUF, v);
      repeat (8) @(posedge clock);
      e = {s[1:0] == 2'b00, s[1:0] == 2'b01, s[1], s[1], !s[2], s[2], s[2], v[12:8], v[5:2]};
      chk({xo, scm, sdf, sbi, pcm, pdf, pbi, load, drive}, e);
    end
    wr(`RFS_OFS_MUX, 16'h0002);
    ref_select_pin <= 1'b0;
    dividers_lockable <= 1'b1;
    wr(`RFS_OFS_ZDM, 16'h0500);
    repeat (8) @(posedge clock);
    chk(16'({rpri, fbs, fb2, acq}), 16'h000D);
    dividers_lockable <= 1'b0;
    wr(`RFS_OFS_ZDM, 16'h0100); // channel two assumed powered
    repeat (8) @(posedge clock);
    chk(16'({rpri, fbs, fb2, acq}), 16'h000A);
    wr(`RFS_OFS_ZDM, 16'h0000);
    repeat (8) @(posedge clock);
    chk(16'({rpri, fbs, fb2, acq}), 16'h0000);
    wr(`RFS_OFS_MUX, 16'h0003);
    wr(`RFS_OFS_RDIV, 16'h0003);
    repeat (8) @(posedge clock);
    tcount(2'h0, 20);
    tcount(2'h2, 10);
    wr(`RFS_OFS_BYPASS, 16'h0001);
    repeat (8) @(posedge clock);
    chk(16'(bye), 16'h0001);
    tcount(2'h1, 60);
    wr(`RFS_OFS_BYPASS, 16'h0003);
    repeat (8) @(posedge clock);
    tcount(2'h1, 10);
    wr(`RFS_OFS_BYPASS, 16'h0000);
    repeat (8) @(posedge clock);
    chk(16'(bye), 16'h0000);
    tcount(2'h1, 0);
    wr(`RFS_OFS_RDIV, 16'h0000);
    repeat (8) @(posedge clock);
    chk(16'(dbl), 16'h0001);
    tcount(2'h0, 120);
    results;
  end
endmodule
